// File: rtl/nvbc_nvm_store.sv
// One-time storage: fixed factory bank and two user banks
`timescale 1ns/100ps
module nvbc_nvm_store (
   input  wire logic       clk,        // System clock
   input  wire logic       rst_n,      // Synchronised reset, active low
   input  wire logic       wr_en,      // Write a byte into the next free bank
   input  wire logic [2:0] wr_idx,     // Byte index of the write
   input  wire logic [7:0] wr_data,    // Byte to store
   input  wire logic       burn_done,  // Marks the free bank as burned
   input  wire logic [2:0] rd_idx,     // Byte index to read
   output logic      [7:0] rd_data,    // Byte of the newest burned bank
   output logic      [1:0] used_cnt    // Number of burned user banks
);
   // Factory image, fixed; values arbitrary
   localparam logic [7:0][7:0] FACTORY_IMG = 64'h0706050403020100;

   nvbc_pkg::nvbc_store_s q;
   nvbc_pkg::nvbc_store_s n;

   // Burn into the free bank; counter stops at the bank limit
   always_comb begin
      n = q;
      if (wr_en && q.used < nvbc_pkg::USER_BANKS) begin
         n.user[q.used[0]][wr_idx] = wr_data;
      end
      if (burn_done && q.used < nvbc_pkg::USER_BANKS) begin
         n.used = q.used + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // Read the newest bank, factory bank when nothing is burned
   always_comb begin
      if (q.used == 2'h0) begin
         rd_data = FACTORY_IMG[rd_idx];
      end else begin
         rd_data = q.user[q.used[1] ? 1 : 0][rd_idx];
      end
   end
   assign used_cnt = q.used;

   chk_bank_limit: assert property (@(posedge clk) disable iff (!rst_n)
      q.used <= nvbc_pkg::USER_BANKS) else $error("more than two user banks burned");
   chk_factory_fixed: assert property (@(posedge clk) disable iff (!rst_n)
      q.used == 2'h0 |-> rd_data == FACTORY_IMG[rd_idx]) else $error("factory bank changed");
endmodule

// File: rtl/nvbc_pkg.sv
// Constants and types shared by the bank burn control block
package nvbc_pkg;
   // Register addresses (page in the high byte, offset in the low byte)
   localparam logic [15:0] ADDR_CUR_BANK  = 16'h00e2;
   localparam logic [15:0] ADDR_BURN_CMD  = 16'h00e3;
   localparam logic [15:0] ADDR_RELOAD    = 16'h00e4;
   localparam logic [15:0] ADDR_HARD_RST  = 16'h001e;
   localparam logic [15:0] ADDR_TAG_FIRST = 16'h026b;
   localparam logic [15:0] ADDR_TAG_LAST  = 16'h0272;
   localparam logic [7:0]  OFFS_READY     = 8'hfe;
   // Field positions and command values
   localparam int          RELOAD_BIT     = 0;
   localparam int          HARD_RST_BIT   = 1;
   localparam logic [7:0]  BURN_KEY       = 8'hc7;
   localparam logic [7:0]  READY_IDLE     = 8'h0f;
   localparam logic [7:0]  READY_BUSY     = 8'h00;
   localparam logic [7:0]  RD_NONE        = 8'h00;
   // Current bank codes by number of burned user banks
   localparam logic [7:0]  BANK_FACTORY   = 8'h03;
   localparam logic [7:0]  BANK_ONE       = 8'h0f;
   localparam logic [7:0]  BANK_TWO       = 8'h3f;
   localparam logic [1:0]  USER_BANKS     = 2'h2;
   // Configuration image: eight bytes, user tag bytes
   localparam int          CFG_BYTES      = 8;
   localparam logic [2:0]  CFG_LAST       = 3'h7;
   // Settle time after a burn or download
   localparam int          CLK_MHZ        = 125;
   localparam int          SETTLE_NS      = 200;
   localparam int          SETTLE_CYC     = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0]  SETTLE_LAST    = 8'(SETTLE_CYC - 1);

   typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_BURN, ST_SETTLE} nvbc_state_e;

   // Top-level state
   typedef struct packed {
      nvbc_state_e     st;
      logic [2:0]      idx;
      logic [7:0]      wait_cnt;
      logic [7:0][7:0] cfg;
      logic [7:0]      bank_code;
      logic [7:0]      rdata;
      logic            rvalid;
      logic [2:0]      pin_sync;
      logic            pin_level;
   } nvbc_top_s;

   // Storage state: two user banks and the burned-bank count
   typedef struct packed {
      logic [1:0][7:0][7:0] user;
      logic [1:0]           used;
   } nvbc_store_s;
endpackage

// File: rtl/nvbc_top.sv
// Burn, reload and ready reporting for the user storage banks
`timescale 1ns/100ps
// Behaviour
// - There is one factory bank and two user banks, so at most two burns succeed.
// - The factory bank contents are constant and never written.
// - The current bank value reads 3 unburned, 15 after one burn, 63 after two, from the next download after the burn on.
// - The current bank value is read from its own 8-bit register.
// - A burn starts only when 0xC7 is written to the burn command register.
// - A burn copies the configuration registers into the next free user bank.
// - The ready register reads 0x0F once commands are accepted again.
// - The ready register answers at offset 0xFE on every page.
// - Writing 1 to the reload bit copies the stored bank back into the registers.
// - A hard reset from pin, register bit or power-on also reloads stored contents.
// - The hard reset bit restores every register from storage like a power cycle.
module nvbc_top (
   input  wire logic        CLK,          // 125 MHz clock
   input  wire logic        RESETN,       // Power-on reset, active low
   input  wire logic        FULL_RESET_N, // Hard reset pin, active low
   input  wire logic [15:0] REG_ADDR,     // Register address, page in high byte
   input  wire logic        REG_WR,       // Write strobe
   input  wire logic        REG_RD,       // Read strobe
   input  wire logic [7:0]  REG_WDATA,    // Write data
   output logic      [7:0]  REG_RDATA,    // Read data, registered
   output logic             REG_RVALID,   // Read data valid pulse
   output logic             BUSY          // Burn or download in progress
);
   logic                rst_meta_ff;
   logic                rst_n_ff;
   nvbc_pkg::nvbc_top_s q;
   nvbc_pkg::nvbc_top_s n;
   logic [7:0]          rd_byte;
   logic [1:0]          used_cnt;
   logic                busy;
   logic                wr_ok;
   logic [15:0]         tag_off;

   // Ready register answers on every page
   function automatic logic is_ready(input logic [15:0] a);
      return a[7:0] == nvbc_pkg::OFFS_READY;
   endfunction

   // Bank code from the number of burned banks
   function automatic logic [7:0] bank_code(input logic [1:0] used);
      if (used == 2'h0) begin
         return nvbc_pkg::BANK_FACTORY;
      end else if (used == 2'h1) begin
         return nvbc_pkg::BANK_ONE;
      end else begin
         return nvbc_pkg::BANK_TWO;
      end
   endfunction

   // Reset release through two flip-flops
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   assign busy    = q.st != nvbc_pkg::ST_IDLE;
   assign wr_ok   = REG_WR && !busy;
   assign tag_off = REG_ADDR - nvbc_pkg::ADDR_TAG_FIRST;

   nvbc_nvm_store u_store (
      .clk       (CLK),
      .rst_n     (rst_n_ff),
      .wr_en     (q.st == nvbc_pkg::ST_BURN),
      .wr_idx    (q.idx),
      .wr_data   (q.cfg[q.idx]),
      .burn_done (q.st == nvbc_pkg::ST_BURN && q.idx == nvbc_pkg::CFG_LAST),
      .rd_idx    (q.idx),
      .rd_data   (rd_byte),
      .used_cnt  (used_cnt)
   );

   // Register access, sequencer and hard reset pin filter
   always_comb begin
      n          = q;
      n.rvalid   = REG_RD;
      n.pin_sync = {q.pin_sync[1:0], FULL_RESET_N};
      if (q.pin_sync[1] == q.pin_sync[2]) begin
         n.pin_level = q.pin_sync[2];
      end
      // Read decode
      if (REG_RD) begin
         if (is_ready(REG_ADDR)) begin
            n.rdata = busy ? nvbc_pkg::READY_BUSY : nvbc_pkg::READY_IDLE;
         end else if (busy) begin
            n.rdata = nvbc_pkg::RD_NONE;
         end else if (REG_ADDR == nvbc_pkg::ADDR_CUR_BANK) begin
            n.rdata = q.bank_code;
         end else if (REG_ADDR == nvbc_pkg::ADDR_RELOAD) begin
            n.rdata = nvbc_pkg::RD_NONE;
         end else if (REG_ADDR >= nvbc_pkg::ADDR_TAG_FIRST
                      && REG_ADDR <= nvbc_pkg::ADDR_TAG_LAST) begin
            n.rdata = q.cfg[tag_off[2:0]];
         end else begin
            n.rdata = nvbc_pkg::RD_NONE;
         end
      end
      // Sequencer
      case (q.st)
         nvbc_pkg::ST_LOAD: begin
            n.cfg[q.idx] = rd_byte;
            n.idx        = q.idx + 3'h1;
            if (q.idx == nvbc_pkg::CFG_LAST) begin
               n.bank_code = bank_code(used_cnt);
               n.wait_cnt  = '0;
               n.st        = nvbc_pkg::ST_SETTLE;
            end
         end
         nvbc_pkg::ST_BURN: begin
            n.idx = q.idx + 3'h1;
            if (q.idx == nvbc_pkg::CFG_LAST) begin
               n.wait_cnt = '0;
               n.st       = nvbc_pkg::ST_SETTLE;
            end
         end
         nvbc_pkg::ST_SETTLE: begin
            n.wait_cnt = q.wait_cnt + 8'h01;
            if (q.wait_cnt == nvbc_pkg::SETTLE_LAST) begin
               n.st = nvbc_pkg::ST_IDLE;
            end
         end
         default: begin
            if (wr_ok && REG_ADDR == nvbc_pkg::ADDR_BURN_CMD
                && REG_WDATA == nvbc_pkg::BURN_KEY
                && used_cnt < nvbc_pkg::USER_BANKS) begin
               n.idx = '0;
               n.st  = nvbc_pkg::ST_BURN;
            end else if (wr_ok && REG_ADDR == nvbc_pkg::ADDR_RELOAD
                         && REG_WDATA[nvbc_pkg::RELOAD_BIT]) begin
               n.idx = '0;
               n.st  = nvbc_pkg::ST_LOAD;
            end else if (wr_ok && REG_ADDR == nvbc_pkg::ADDR_HARD_RST
                         && REG_WDATA[nvbc_pkg::HARD_RST_BIT]) begin
               n.idx = '0;
               n.st  = nvbc_pkg::ST_LOAD;
            end else if (wr_ok && REG_ADDR >= nvbc_pkg::ADDR_TAG_FIRST
                         && REG_ADDR <= nvbc_pkg::ADDR_TAG_LAST) begin
               n.cfg[tag_off[2:0]] = REG_WDATA;
            end
         end
      endcase
      // Hard reset pin falling edge restarts the download from any state
      if (q.pin_level && !n.pin_level) begin
         n.idx = '0;
         n.st  = nvbc_pkg::ST_LOAD;
      end
   end

   // State register; power-on starts with a download
   always_ff @(posedge CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         q           <= '0;
         q.st        <= nvbc_pkg::ST_LOAD;
         q.bank_code <= nvbc_pkg::BANK_FACTORY;
         q.pin_sync  <= 3'h7;
         q.pin_level <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign REG_RDATA  = q.rdata;
   assign REG_RVALID = q.rvalid;
   assign BUSY       = busy;

   chk_ready_busy: assert property (@(posedge CLK) disable iff (!rst_n_ff)
      REG_RD && is_ready(REG_ADDR) && busy |=> REG_RVALID && REG_RDATA != nvbc_pkg::READY_IDLE)
      else $error("ready code shown while busy");
   chk_ready_idle: assert property (@(posedge CLK) disable iff (!rst_n_ff)
      REG_RD && is_ready(REG_ADDR) && !busy |=> REG_RDATA == nvbc_pkg::READY_IDLE)
      else $error("ready code missing while idle");
   chk_burn_start: assert property (@(posedge CLK) disable iff (!rst_n_ff)
      q.st == nvbc_pkg::ST_IDLE && wr_ok && REG_ADDR == nvbc_pkg::ADDR_BURN_CMD
      && REG_WDATA == nvbc_pkg::BURN_KEY && used_cnt < nvbc_pkg::USER_BANKS
      && q.pin_level == n.pin_level |=> q.st == nvbc_pkg::ST_BURN && q.idx == 3'h0)
      else $error("burn key did not start a burn");
   chk_burn_bad_key: assert property (@(posedge CLK) disable iff (!rst_n_ff)
      $rose(q.st == nvbc_pkg::ST_BURN) |-> $past(REG_WDATA) == nvbc_pkg::BURN_KEY
      && $past(REG_ADDR) == nvbc_pkg::ADDR_BURN_CMD)
      else $error("burn started without the key");
   // A hard reset pin edge may cut a burn short, so that case is left out
   chk_burn_length: assert property (@(posedge CLK)
      disable iff (!rst_n_ff || !q.pin_level)
      $rose(q.st == nvbc_pkg::ST_BURN)
      |-> (q.st == nvbc_pkg::ST_BURN)[*8] ##1 q.st == nvbc_pkg::ST_SETTLE)
      else $error("burn did not copy eight bytes");
   chk_bank_code: assert property (@(posedge CLK) disable iff (!rst_n_ff)
      $rose(q.st == nvbc_pkg::ST_SETTLE) && $past(q.st) == nvbc_pkg::ST_LOAD
      |-> q.bank_code == bank_code(used_cnt))
      else $error("bank code does not match burned banks");
   chk_reload_start: assert property (@(posedge CLK) disable iff (!rst_n_ff)
      wr_ok && REG_ADDR == nvbc_pkg::ADDR_RELOAD && REG_WDATA[nvbc_pkg::RELOAD_BIT]
      |=> q.st == nvbc_pkg::ST_LOAD)
      else $error("reload bit did not start a download");
   chk_hard_bit: assert property (@(posedge CLK) disable iff (!rst_n_ff)
      wr_ok && REG_ADDR == nvbc_pkg::ADDR_HARD_RST && REG_WDATA[nvbc_pkg::HARD_RST_BIT]
      |=> q.st == nvbc_pkg::ST_LOAD)
      else $error("hard reset bit did not reload");
   chk_pin_reload: assert property (@(posedge CLK) disable iff (!rst_n_ff)
      $fell(q.pin_level) |-> q.st == nvbc_pkg::ST_LOAD && q.idx == 3'h0)
      else $error("hard reset pin did not reload");
   chk_load_ends: assert property (@(posedge CLK) disable iff (!rst_n_ff)
      $rose(q.st == nvbc_pkg::ST_LOAD) |-> ##[1:60] q.st == nvbc_pkg::ST_IDLE)
      else $error("download did not finish in time");
endmodule

// File: sim/nvbc_host.sv
// Host model on the register port: one-cycle byte writes and reads
`timescale 1ns/100ps
module nvbc_host (
   input  wire logic        clk,        // System clock
   output logic      [15:0] reg_addr,   // Register address
   output logic             reg_wr,     // Write strobe
   output logic             reg_rd,     // Read strobe
   output logic      [7:0]  reg_wdata,  // Write data
   input  wire logic [7:0]  reg_rdata   // Read data
);
   // Idle bus at time zero
   initial begin
      reg_addr = 16'hffff;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'hff;
   end

   // One write; callers touch only the ready register while busy
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   // One read; the byte stands valid the cycle after the strobe edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule

// File: sim/nvbc_top_tb.sv
// Self-checking bench: burns, reloads and hard resets through the register port and the hard reset pin
`timescale 1ns/100ps
module nvbc_top_tb;
   logic        clk;
   logic        resetn;
   logic        full_reset_n;
   logic [15:0] reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        reg_rvalid;
   logic        busy;
   int          n_errors = 0;
   int          samples_checked = 0;
   integer      seed = 32'h098a;
   logic [24:0] exp_q[$];
   logic [24:0] note;
   logic [7:0]  tags[8];
   logic [7:0]  kept[8];
   logic [7:0]  codes[4];

   nvbc_top dut (.CLK(clk), .RESETN(resetn), .FULL_RESET_N(full_reset_n),
      .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
      .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .BUSY(busy));
   nvbc_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // Clock and power-on reset
   always #4 clk = ~clk;
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      full_reset_n = 1'b1;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
   end

   // Let the last answer reach the watcher, then demand that every read was answered
   task automatic complete_run;
      @(posedge clk);
      check8("reads left unanswered", 8'h00, 8'(exp_q.size()));
      if (n_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic check_bit(input string what, input logic e, input logic g);
      check8(what, {7'h00, e}, {7'h00, g});
   endtask

   // Read with a noted expectation
   task automatic rd_exp(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] v;
      exp_q.push_back({1'b1, a, e});
      host.rd(a, v);
   endtask

   // Poll ready on changing pages until idle, bounded
   task automatic poll_ready;
      logic [7:0] v;
      int i;
      rd_exp({8'h03, nvbc_pkg::OFFS_READY}, nvbc_pkg::READY_BUSY);
      v = 8'h00;
      for (i = 0; i < 100 && v !== nvbc_pkg::READY_IDLE; i++) begin
         exp_q.push_back({1'b0, 16'h0000, 8'h00});
         host.rd({8'(i), nvbc_pkg::OFFS_READY}, v);
      end
      check8("ready", nvbc_pkg::READY_IDLE, v);
      if (v !== nvbc_pkg::READY_IDLE) complete_run();
      check_bit("busy when ready", 1'b0, busy);
   endtask

   task automatic wait_busy;
      int i;
      for (i = 0; i < 10 && busy !== 1'b1; i++) @(negedge clk);
      check_bit("busy after trigger", 1'b1, busy);
      if (busy !== 1'b1) complete_run();
   endtask

   // Each read answer is matched against the oldest note
   always @(negedge clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("[FAIL] read answer expected none seen %h", reg_rdata);
         end else begin
            note = exp_q.pop_front();
            if (note[24]) check8($sformatf("read %h", note[23:8]), note[7:0], reg_rdata);
         end
      end
   end

   // Main sequence: factory state, two burns, a refused third burn
   initial begin
      codes = '{nvbc_pkg::BANK_FACTORY, nvbc_pkg::BANK_ONE, nvbc_pkg::BANK_TWO,
                nvbc_pkg::BANK_TWO};
      @(posedge resetn);
      // The design leaves reset two edges after the pin; a read before that is lost
      repeat (2) @(negedge clk);
      poll_ready();
      rd_exp(nvbc_pkg::ADDR_CUR_BANK, nvbc_pkg::BANK_FACTORY);
      for (int i = 0; i < 8; i++) begin
         rd_exp(nvbc_pkg::ADDR_TAG_FIRST + 16'(i), 8'(i));
      end
      for (int b = 0; b < 3; b++) begin
         for (int i = 0; i < 8; i++) begin
            tags[i] = 8'($random(seed));
            host.wr(nvbc_pkg::ADDR_TAG_FIRST + 16'(i), tags[i]);
            if (b < 2) kept[i] = tags[i];
         end
         host.wr(nvbc_pkg::ADDR_BURN_CMD, nvbc_pkg::BURN_KEY ^ 8'h01);
         check_bit("busy after wrong key", 1'b0, busy);
         host.wr(nvbc_pkg::ADDR_CUR_BANK, 8'h55);
         host.wr(nvbc_pkg::ADDR_BURN_CMD, nvbc_pkg::BURN_KEY);
         check_bit("busy after key", b < 2, busy);
         if (b < 2) poll_ready();
         rd_exp(nvbc_pkg::ADDR_BURN_CMD, 8'h00);
         rd_exp(nvbc_pkg::ADDR_CUR_BANK, codes[b]);
         if (b == 0) host.wr(nvbc_pkg::ADDR_RELOAD, 8'h01);
         if (b == 1) host.wr(nvbc_pkg::ADDR_HARD_RST, 8'h02);
         if (b == 2) begin
            @(negedge clk);
            full_reset_n = 1'b0;
         end
         wait_busy();
         full_reset_n = 1'b1;
         poll_ready();
         rd_exp(nvbc_pkg::ADDR_RELOAD, 8'h00);
         rd_exp(nvbc_pkg::ADDR_CUR_BANK, codes[b + 1]);
         for (int i = 0; i < 8; i++) begin
            rd_exp(nvbc_pkg::ADDR_TAG_FIRST + 16'(i), kept[i]);
         end
      end
      complete_run();
   end
endmodule
